// ### bmd_pkg.sv
// shared constants, types and layouts of the banked data memory decoder
package bmd_pkg;

   // ----------------------------------------------------------------------
   // address layout
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int BANK_W = 6;
   localparam int OFS_W = 7;
   localparam int DATA_W = 8;
   localparam int MAX_BANKS = 64;
   localparam int BANK_BYTES = 128;
   localparam int CORE_REGS = 12;
   localparam int GPR_PER_BANK = 80;
   localparam int COMMON_BYTES = 16;
   localparam int GPR_BANKS_MAX = 60;

   // ----------------------------------------------------------------------
   // region boundaries inside one bank
   // ----------------------------------------------------------------------
   localparam logic [OFS_W-1:0] CORE_COUNT = 7'h0C;
   localparam logic [OFS_W-1:0] SFR_LO_TOP = 7'h20;
   localparam logic [OFS_W-1:0] SFR_HI_TOP = 7'h70;
   localparam logic [OFS_W-1:0] GPR_BASE = 7'h20;
   localparam logic [OFS_W-1:0] GPR_TOP = 7'h70;
   localparam logic [OFS_W-1:0] COMMON_BASE = 7'h70;
   localparam logic [BANK_W-1:0] SFR_HI_FIRST_BANK = 6'h3C;
   localparam logic [ADDR_W-1:0] GPR_BYTES_W = 13'h0050;

   // ----------------------------------------------------------------------
   // core register offsets and reset values
   // ----------------------------------------------------------------------
   localparam logic [3:0] OFS_IND0 = 4'h0;
   localparam logic [3:0] OFS_IND1 = 4'h1;
   localparam logic [3:0] OFS_PCL = 4'h2;
   localparam logic [3:0] OFS_STATUS = 4'h3;
   localparam logic [3:0] OFS_PTR0_LO = 4'h4;
   localparam logic [3:0] OFS_PTR0_HI = 4'h5;
   localparam logic [3:0] OFS_PTR1_LO = 4'h6;
   localparam logic [3:0] OFS_PTR1_HI = 4'h7;
   localparam logic [3:0] OFS_BSR = 4'h8;
   localparam logic [3:0] OFS_WORKING_REGISTER = 4'h9;
   localparam logic [3:0] OFS_PROGRAM_COUNTER_LATCH_HIGH = 4'hA;
   localparam logic [3:0] OFS_INTERRUPT_CONTROL = 4'hB;
   localparam int IND_PORTS = 2;
   localparam logic [DATA_W-1:0] CORE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] BSR_MASK = 8'h3F;
   localparam logic [DATA_W-1:0] FULL_MASK = 8'hFF;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      BMD_REG_NONE = 3'b000,
      BMD_REG_CORE = 3'b001,
      BMD_REG_SFR = 3'b010,
      BMD_REG_GPR = 3'b011,
      BMD_REG_COMMON = 3'b100
   } bmd_region_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic indirect;
      logic ptr_sel;
      logic [OFS_W-1:0] offset;
      logic [DATA_W-1:0] wdata;
   } bmd_acc_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bmd_sfr_t;

endpackage

// ### bmd_decode.sv
// region decoder: classifies a 13-bit data memory address
`timescale 1ns/1ps
module bmd_decode
   import bmd_pkg::*;
#(
   parameter int GPR_BANKS = 60,
   parameter int GW = 13
) (
   input wire logic [ADDR_W-1:0] addr, // full data memory address
   output bmd_region_t region, // region that the address falls in
   output logic [3:0] sel, // core register or common byte index
   output logic [GW-1:0] gpr_idx // flat index into banked gpr storage
);

   // ----------------------------------------------------------------------
   // field split and per-bank limits
   // ----------------------------------------------------------------------
   wire logic [BANK_W-1:0] bank = addr[ADDR_W-1:OFS_W];
   wire logic [OFS_W-1:0] ofs = addr[OFS_W-1:0];
   // the upper four banks trade all gpr space for a longer slot range
   wire logic hi_bank = (bank >= SFR_HI_FIRST_BANK);
   wire logic [OFS_W-1:0] sfr_top = hi_bank ? SFR_HI_TOP : SFR_LO_TOP;
   wire logic gpr_bank = ({26'h0, bank} < GPR_BANKS);
   wire logic [ADDR_W-1:0] flat = {7'h00, bank} * GPR_BYTES_W + {6'h00, ofs} - {6'h00, GPR_BASE};

   // ----------------------------------------------------------------------
   // classification, core first and common before slots
   // ----------------------------------------------------------------------
   assign region = (ofs < CORE_COUNT) ? BMD_REG_CORE :
                   (ofs >= COMMON_BASE) ? BMD_REG_COMMON :
                   (ofs < sfr_top) ? BMD_REG_SFR :
                   (gpr_bank && ofs < GPR_TOP) ? BMD_REG_GPR :
                   BMD_REG_NONE;
   assign sel = ofs[3:0];
   assign gpr_idx = flat[GW-1:0];

endmodule // bmd_decode

// ### bmd_core.sv
// banked data memory decoder with core registers, gpr and common ram
`timescale 1ns/1ps
module bmd_core
   import bmd_pkg::*;
#(
   parameter int GPR_BANKS = 60
) (
   input wire logic ref_clk, // 25 MHz system clock
   input wire logic rst, // synchronous reset, active high
   input wire bmd_acc_t acc_i, // file access from the processor core
   input wire logic [DATA_W-1:0] sfr_rdata, // slot read data, valid while sfr_req_r is up
   output bmd_region_t region_r, // region of the last decoded access
   output logic rd_valid_r, // read answer strobe
   output logic [DATA_W-1:0] rd_data_r, // read answer data
   output bmd_sfr_t sfr_req_r, // slot access toward the peripherals
   output logic [BANK_W-1:0] bank_select_r, // active bank number
   output logic [DATA_W-1:0] working_r, // working register
   output logic [DATA_W-1:0] status_r, // status flags
   output logic [DATA_W-1:0] pcl_r, // program counter low byte
   output logic [DATA_W-1:0] program_counter_latch_high_r, // program counter latch high
   output logic [DATA_W-1:0] interrupt_control_r, // interrupt control
   output logic [15:0] ptr0_r, // file pointer 0, high and low
   output logic [15:0] ptr1_r // file pointer 1, high and low
);

   // ----------------------------------------------------------------------
   // elaboration checks and derived sizes
   // ----------------------------------------------------------------------
   localparam int GPR_DEPTH = GPR_BANKS * GPR_PER_BANK;
   localparam int GW = (GPR_DEPTH > 1) ? $clog2(GPR_DEPTH) : 1;

   generate
      if (GPR_BANKS < 1 || GPR_BANKS > GPR_BANKS_MAX) begin : g_bad_banks
         $error("bmd_core: GPR_BANKS must lie between 1 and 60");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0] core_r [CORE_REGS];
   logic [DATA_W-1:0] gpr_mem [GPR_DEPTH];
   logic [DATA_W-1:0] com_mem [COMMON_BYTES];

   // ----------------------------------------------------------------------
   // access stage: request held one cycle, decoded against live registers
   // ----------------------------------------------------------------------
   // decoding in this stage, not at capture, means a bank or pointer write
   // is already in effect for the very next access without any stall
   bmd_acc_t s1_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1_r <= '0;
      end else begin
         s1_r <= acc_i;
      end
   end

   // pointer views of the stored pointer bytes
   wire logic [15:0] ptr0_w = {core_r[OFS_PTR0_HI], core_r[OFS_PTR0_LO]};
   wire logic [15:0] ptr1_w = {core_r[OFS_PTR1_HI], core_r[OFS_PTR1_LO]};

   // a direct access to offset 0 or 1 of any bank goes through a pointer
   wire logic port_hit = !s1_r.indirect && (s1_r.offset[OFS_W-1:1] == 6'h00);
   wire logic use_ptr = s1_r.indirect || port_hit;
   wire logic which_ptr = s1_r.indirect ? s1_r.ptr_sel : s1_r.offset[0];
   wire logic [15:0] ptr_sel_w = which_ptr ? ptr1_w : ptr0_w;
   // pointers ignore bank select entirely, so gpr walks run across banks
   wire logic [ADDR_W-1:0] ptr_addr = ptr_sel_w[ADDR_W-1:0];
   wire logic [ADDR_W-1:0] dir_addr = {core_r[OFS_BSR][BANK_W-1:0], s1_r.offset};
   wire logic [ADDR_W-1:0] eff_addr = use_ptr ? ptr_addr : dir_addr;

   bmd_region_t dec_region;
   logic [3:0] dec_sel;
   logic [GW-1:0] dec_gpr;

   bmd_decode #(
      .GPR_BANKS(GPR_BANKS),
      .GW(GW)
   ) u_decode (
      .addr(eff_addr),
      .region(dec_region),
      .sel(dec_sel),
      .gpr_idx(dec_gpr)
   );

   // a pointer aimed back at an indirect port would recurse: it reads zero
   wire logic self_ref = use_ptr && (dec_region == BMD_REG_CORE) && ({28'h0, dec_sel} < IND_PORTS);
   wire bmd_region_t region = self_ref ? BMD_REG_NONE : dec_region;

   // ----------------------------------------------------------------------
   // write enables per region
   // ----------------------------------------------------------------------
   // unimplemented addresses raise no enable at all
   wire logic wr = s1_r.valid && s1_r.write;
   wire logic core_we = wr && (region == BMD_REG_CORE);
   wire logic gpr_we = wr && (region == BMD_REG_GPR);
   wire logic com_we = wr && (region == BMD_REG_COMMON);
   wire logic sfr_hit = s1_r.valid && (region == BMD_REG_SFR);

   // ----------------------------------------------------------------------
   // core register file, one flop group per offset
   // ----------------------------------------------------------------------
   // the indirect ports hold no storage of their own and stay at zero
   genvar gi;
   generate
      for (gi = 0; gi < CORE_REGS; gi++) begin : g_core
         localparam logic [3:0] IDX = 4'(gi);
         localparam logic [DATA_W-1:0] MASK = (IDX == OFS_BSR) ? BSR_MASK : FULL_MASK;
         wire logic we_i = core_we && (dec_sel == IDX) && (gi >= IND_PORTS);
         // bank select keeps only its six implemented bits
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               core_r[gi] <= CORE_RESET;
            end else if (we_i) begin
               core_r[gi] <= s1_r.wdata & MASK;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // gpr and common ram
   // ----------------------------------------------------------------------
   // ram contents are left unreset; only control state has a reset value
   always_ff @(posedge ref_clk) begin
      if (gpr_we) begin
         gpr_mem[dec_gpr] <= s1_r.wdata;
      end
   end

   // common bytes index by offset alone, so every bank lands on one copy
   always_ff @(posedge ref_clk) begin
      if (com_we) begin
         com_mem[dec_sel] <= s1_r.wdata;
      end
   end

   // ----------------------------------------------------------------------
   // local read selection
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0] local_rd;

   always_comb begin
      local_rd = READ_ZERO;
      case (region)
         BMD_REG_CORE: begin
            local_rd = core_r[dec_sel];
         end
         BMD_REG_GPR: begin
            local_rd = gpr_mem[dec_gpr];
         end
         BMD_REG_COMMON: begin
            local_rd = com_mem[dec_sel];
         end
         default: begin
            local_rd = READ_ZERO;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // answer stage: slot request goes out, local data waits one cycle
   // ----------------------------------------------------------------------
   // every read answers two cycles after capture, whichever region it hits,
   // which costs a cycle on local reads but keeps the core's timing flat
   logic s2_valid_r;
   logic s2_write_r;
   logic s2_sfr_r;
   logic [DATA_W-1:0] s2_data_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s2_valid_r <= 1'b0;
         s2_write_r <= 1'b0;
         s2_sfr_r <= 1'b0;
         s2_data_r <= READ_ZERO;
         region_r <= BMD_REG_NONE;
      end else begin
         s2_valid_r <= s1_r.valid;
         s2_write_r <= s1_r.write;
         s2_sfr_r <= sfr_hit;
         s2_data_r <= local_rd;
         region_r <= s1_r.valid ? region : region_r;
      end
   end

   // slot accesses carry the full address so peripherals decode it themselves
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sfr_req_r <= '0;
      end else begin
         sfr_req_r.valid <= sfr_hit;
         sfr_req_r.write <= sfr_hit && s1_r.write;
         sfr_req_r.addr <= eff_addr;
         sfr_req_r.wdata <= s1_r.wdata;
      end
   end

   // reads only; local writes finish silently in the access stage
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_valid_r <= 1'b0;
         rd_data_r <= READ_ZERO;
      end else begin
         rd_valid_r <= s2_valid_r && !s2_write_r;
         rd_data_r <= s2_sfr_r ? sfr_rdata : s2_data_r;
      end
   end

   // ----------------------------------------------------------------------
   // core register views for the processor
   // ----------------------------------------------------------------------
   assign bank_select_r = core_r[OFS_BSR][BANK_W-1:0];
   assign working_r = core_r[OFS_WORKING_REGISTER];
   assign status_r = core_r[OFS_STATUS];
   assign pcl_r = core_r[OFS_PCL];
   assign program_counter_latch_high_r = core_r[OFS_PROGRAM_COUNTER_LATCH_HIGH];
   assign interrupt_control_r = core_r[OFS_INTERRUPT_CONTROL];
   assign ptr0_r = ptr0_w;
   assign ptr1_r = ptr1_w;

endmodule // bmd_core

// ### bmd_core_monitor.sv
// assertion checker watching the ports of the banked data memory decoder
`timescale 1ns/1ps
module bmd_core_monitor
   import bmd_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst, // synchronous reset
   input wire bmd_acc_t acc_i, // core access
   input wire logic [DATA_W-1:0] sfr_rdata, // slot read data
   input wire bmd_region_t region_r, // decoded region
   input wire logic rd_valid_r, // read strobe
   input wire logic [DATA_W-1:0] rd_data_r, // read data
   input wire bmd_sfr_t sfr_req_r, // slot request
   input wire logic [BANK_W-1:0] bank_select_r, // active bank
   input wire logic [DATA_W-1:0] working_r // working register
);
   // ------------------------------------------------------------
   // access classes
   // ------------------------------------------------------------
   wire logic rd_take = acc_i.valid && !acc_i.write;
   wire logic dir_acc = acc_i.valid && !acc_i.indirect;
   wire logic dir_wr = dir_acc && acc_i.write;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // answer flop is loaded two edges after the taking edge, seen at the third
   property p_rd_lat; rd_take |-> ##3 rd_valid_r; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_rd_cause; rd_valid_r |-> $past(rd_take, 3); endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
   property p_bank;
      dir_wr && acc_i.offset == 7'h08 |-> ##2 bank_select_r == $past(acc_i.wdata[5:0], 2);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select not updated");
   property p_working_register; dir_wr && acc_i.offset == 7'h09 |-> ##2 working_r == $past(acc_i.wdata, 2);
   endproperty
   a_working_register: assert property (p_working_register) else $error("working register wrong");
   property p_core; dir_acc && acc_i.offset inside {[2:11]} |-> ##2 region_r == BMD_REG_CORE;
   endproperty
   a_core: assert property (p_core) else $error("core offset missed");
   property p_common; dir_acc && acc_i.offset >= 7'h70 |-> ##2 region_r == BMD_REG_COMMON;
   endproperty
   a_common: assert property (p_common) else $error("common byte missed");
   property p_slot_src; sfr_req_r.valid |-> region_r == BMD_REG_SFR && $past(acc_i.valid, 2);
   endproperty
   a_slot_src: assert property (p_slot_src) else $error("stray slot request");
   property p_slot_lo;
      dir_acc && acc_i.offset inside {[12:31]}
         |-> ##2 sfr_req_r.valid && sfr_req_r.addr[6:0] == $past(acc_i.offset, 2);
   endproperty
   a_slot_lo: assert property (p_slot_lo) else $error("slot not forwarded");
   property p_slot_rd;
      sfr_req_r.valid && !sfr_req_r.write |=> rd_valid_r && rd_data_r == $past(sfr_rdata);
   endproperty
   a_slot_rd: assert property (p_slot_rd) else $error("slot data lost");
   property p_none;
      rd_valid_r && $past(region_r) == BMD_REG_NONE |-> rd_data_r == READ_ZERO;
   endproperty
   a_none: assert property (p_none) else $error("hole read not zero");
endmodule // bmd_core_monitor

bind bmd_core bmd_core_monitor u_mon (.ref_clk, .rst, .acc_i, .sfr_rdata, .region_r,
   .rd_valid_r, .rd_data_r, .sfr_req_r, .bank_select_r, .working_r);

// ### bmd_periph_model.sv
// peripheral slot model answering forwarded slot accesses
`timescale 1ns/1ps
module bmd_periph_model
   import bmd_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire bmd_sfr_t req, // slot request from the decoder
   output logic [DATA_W-1:0] rdata // slot read data
);
   logic [DATA_W-1:0] mem [0:8191];
   logic [DATA_W-1:0] idle_r = 8'hA5;
   // address-derived start pattern keeps unwritten slots predictable
   initial begin
      for (int i = 0; i < 8192; i++) begin
         mem[i] = i[7:0] ^ 8'h5A;
      end
   end
   // idle bus toggles so a stale value never passes for an answer
   // plain always: the table is also filled by the initial block above
   always @(posedge ref_clk) begin
      idle_r <= ~idle_r;
      if (req.valid && req.write) mem[req.addr] <= req.wdata;
   end
   assign rdata = (req.valid && !req.write) ? mem[req.addr] : idle_r;
endmodule // bmd_periph_model

// ### bmd_core_tb.sv
// self-checking bench for the banked data memory decoder
`timescale 1ns/1ps
module bmd_core_tb
   import bmd_pkg::*;
;
   // ------------------------------------------------------------
   // signals and reference state
   // ------------------------------------------------------------
   localparam int NB = 2; // few gpr banks leave many holes to probe
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   bmd_acc_t acc_i = '0;
   wire logic [DATA_W-1:0] sfr_rdata;
   bmd_region_t region_r;
   bmd_sfr_t sfr_req_r;
   logic rd_valid_r;
   logic [BANK_W-1:0] bank_select_r;
   logic [DATA_W-1:0] rd_data_r, working_r, status_r, pcl_r, program_counter_latch_high_r, interrupt_control_r;
   logic [15:0] ptr0_r, ptr1_r;
   int miscompares = 0;
   int n_tests = 0;
   int mem [8192]; // -1 marks bytes of unknown content
   int core [12];
   int banks [7] = '{0, 1, 2, 59, 60, 63, 255};
   int ofss [7] = '{12, 31, 32, 100, 111, 112, 127};
   // free-running clock
   always #20 ref_clk = ~ref_clk;
   bmd_core #(.GPR_BANKS(NB)) uut (.ref_clk, .rst, .acc_i, .sfr_rdata, .region_r,
      .rd_valid_r, .rd_data_r, .sfr_req_r, .bank_select_r, .working_r, .status_r, .pcl_r,
      .program_counter_latch_high_r, .interrupt_control_r, .ptr0_r, .ptr1_r);
   bmd_periph_model partner (.ref_clk, .req(sfr_req_r), .rdata(sfr_rdata));
   // region of a full address: 0 hole, 1 core, 2 slot, 3 gpr, 4 common
   function automatic int reg_of(int a);
      if ((a & 127) < 12) return 1;
      if ((a & 127) >= 112) return 4;
      if ((a & 127) < 32 || (a >> 7) >= 60) return 2;
      if ((a >> 7) < NB) return 3;
      return 0;
   endfunction
   task automatic chk(input logic [15:0] s, input int e);
      n_tests++;
      if (s !== 16'(e)) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, 16'(e));
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one access, modelled then compared; offsets 0/1 go through a pointer
   task automatic acc(input int wr, ind, ps, ofs, wd);
      int iv, pv, a, o, r, k, e;
      iv = ind || ofs < 2;
      pv = ind ? ps : ofs;
      a = pv ? core[7] * 256 + core[6] : core[5] * 256 + core[4];
      a = iv ? a & 8191 : core[8] * 128 + ofs;
      o = a & 127;
      r = (iv && o < 2) ? 0 : reg_of(a);
      k = (r == 4) ? o : a;
      e = (r == 1) ? core[o] : (r > 1) ? mem[k] : 0;
      @(posedge ref_clk);
      acc_i <= {1'b1, wr[0], ind[0], ps[0], ofs[6:0], wd[7:0]};
      @(posedge ref_clk);
      acc_i.valid <= 1'b0;
      if (wr && r == 1) core[o] = (o == 8) ? wd & 63 : wd & 255;
      if (wr && r > 1) mem[k] = wd & 255;
      @(posedge ref_clk);
      #1 chk(16'(region_r), r);
      @(posedge ref_clk);
      #1 chk(16'(rd_valid_r), !wr);
      if (!wr && e >= 0) chk(16'(rd_data_r), e);
      chk(16'(bank_select_r), core[8]);
      chk(16'(working_r), core[9]);
      chk(16'(pcl_r), core[2]);
      chk(16'(status_r), core[3]);
      chk(16'(program_counter_latch_high_r), core[10]);
      chk(16'(interrupt_control_r), core[11]);
      chk(ptr0_r, core[5] * 256 + core[4]);
      chk(ptr1_r, core[7] * 256 + core[6]);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int v;
      v = $urandom(32'h338D4BFB);
      for (int i = 0; i < 8192; i++) begin
         mem[i] = (reg_of(i) == 2) ? (i & 255) ^ 90 : -1;
      end
      foreach (core[i]) core[i] = 0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1 chk(ptr0_r, 0);
      // core set written once, then read back from banks 0, 1, 2, 59, 60 and 63
      for (int o = 2; o < 12; o++) begin
         if (o != 8) acc(1, 0, 0, o, o * 17);
      end
      foreach (banks[j]) begin
         acc(1, 0, 0, 8, banks[j]);
         for (int o = 2; o < 12; o++) begin
            acc(0, 0, 0, o, 0);
         end
         foreach (ofss[m]) begin
            acc(0, 0, 0, ofss[m], 0);
            acc(1, 0, 0, ofss[m], j * 16 + m);
            acc(0, 0, 0, ofss[m], 0);
         end
      end
      // pointers reach gpr of another bank and refuse the port offsets
      acc(1, 0, 0, 8, 0);
      acc(1, 0, 0, 4, 8'hB0);
      acc(1, 0, 0, 5, 8'hE0);
      acc(1, 0, 0, 0, 8'h3C);
      acc(0, 1, 0, 0, 0);
      acc(1, 0, 0, 6, 1);
      acc(1, 0, 0, 7, 0);
      acc(1, 1, 1, 0, 77);
      acc(0, 0, 0, 1, 0);
      // random traffic over all offsets, pointer values and banks
      repeat (400) begin
         acc($urandom % 2, $urandom % 2, $urandom % 2, $urandom % 128, $urandom % 256);
      end
      end_of_test();
   end
   // watchdog cuts a hang short
   initial begin
      repeat (100000) @(posedge ref_clk);
      miscompares++;
      end_of_test();
   end
endmodule // bmd_core_tb
